/* File: rtl/fsksl_core.sv */
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// RULE1: Two frequency words; a select bit picks which drives the synthesizer.
// RULE2: Each word is three bytes; low byte bit 0 is the spur_spread_enable enable.
// RULE3: Lower band: fref times (3/4 plus (word+spur_spread_enable/2)/32768).
// RULE4: Upper band: fref times (3/2 plus (word+spur_spread_enable/2)/16384).
// RULE5: Band bit 0 picks lower band, 1 picks upper band.
// RULE6: Reference is crystal divided by one plus the 3-bit divider.
// RULE7: Software picks smallest divider meeting reference limits.
// RULE8: Deviation is fref times mantissa times 2^(exponent-16 or -15).
// RULE9: Symbol zero sent at carrier minus deviation, one at plus.
// RULE10: Zero mantissa selects on-off keying.
// RULE11: Shaping bit enables Gaussian transmit shaping.
// RULE12: Software programs receive word as carrier minus IF.
// RULE13: Software should enable dithering for lower spurs.
// RULE14: IF is crystal over 8 times one plus ADC divider.
// RULE15: Software sets filter bypass outside 300-320 kHz IF or high rates.
// RULE16: Channel bandwidth is 307.2 kHz over one plus decimation field.
// RULE17: Software uses decimation 24 or 15 for narrow channels.
// RULE18: Synchronizer aligns bit clock, decides bits by oversampled voting.
// RULE19: Transmitter sends alternating preamble so synchronizer can lock.
// RULE20: Transition recorded on shift beyond expected deviation; level is min/max mean.
// RULE21: Three transitions form a level; slicer_avg_length field lengthens averaging.
// RULE22: Slicer_avg_length zero disables averaging; level assumes symmetry around IF.
module fsksl_core
   import fsksl_pkg::*;
(
   input  wire logic                mclk_i,
   input  wire logic                rst_b_i,
   input  wire logic [7:0]          freq_first_hi_i,
   input  wire logic [7:0]          freq_first_mid_i,
   input  wire logic [7:0]          freq_first_lo_i,
   input  wire logic [7:0]          freq_second_hi_i,
   input  wire logic [7:0]          freq_second_mid_i,
   input  wire logic [7:0]          freq_second_lo_i,
   input  wire logic                freq_select_i,
   input  wire logic                band_choice_i,
   input  wire logic [2:0]          ref_divider_i,
   input  wire logic [3:0]          tx_shift_mantissa_i,
   input  wire logic [2:0]          tx_shift_exponent_i,
   input  wire logic                tx_shaping_i,
   input  wire logic                tx_symbol_i,
   input  wire logic [2:0]          adc_divider_i,
   input  wire logic                filter_bypass_i,
   input  wire logic [4:0]          decimation_factor_i,
   input  wire logic [1:0]          rx_shift_exponent_i,
   input  wire logic [3:0]          rx_shift_mantissa_i,
   input  wire logic [1:0]          slicer_avg_length_i,
   input  wire logic                demod_valid_i,
   input  wire logic signed [11:0]  demod_freq_i,
   input  wire logic                bit_ready_i,
   output logic [FREQ_W-2:0]        synth_word_o,
   output logic                     spur_spread_enable_o,
   output logic                     band_choice_o,
   output logic [2:0]               ref_divider_o,
   output logic [3:0]               ref_div_ratio_o,
   output logic [17:0]              synth_base_o,
   output logic [3:0]               synth_frac_shift_o,
   output logic signed [4:0]        tx_shift_mantissa_o,
   output logic signed [5:0]        tx_shift_power_o,
   output logic                     ook_mode_o,
   output logic                     tx_gauss_o,
   output logic [6:0]               if_div_ratio_o,
   output logic [4:0]               adc_div_ratio_o,
   output logic                     filter_bypass_o,
   output logic [5:0]               chbw_div_ratio_o,
   output logic signed [11:0]       slice_level_o,
   output logic                     slicer_locked_o,
   output logic                     bit_data_o,
   output logic                     bit_valid_o,
   output logic                     fifo_overflow_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Synthesizer and receive-chain configuration mapping.

   logic [FREQ_W-1:0]  word_first;
   logic [FREQ_W-1:0]  word_second;
   logic [FREQ_W-1:0]  word_sel;
   logic [FREQ_W-2:0]  synth_word_next;
   logic               spur_spread_enable_next;
   logic [17:0]        synth_base_next;
   logic [3:0]         frac_shift_next;
   logic signed [5:0]  power_next;
   logic signed [4:0]  mant_next;
   logic [FREQ_W-2:0]  synth_word_reg;
   logic               spur_spread_enable_reg;
   logic               band_reg;
   logic [2:0]         ref_div_reg;
   logic [3:0]         ref_ratio_reg;
   logic [17:0]        synth_base_reg;
   logic [3:0]         frac_shift_reg;
   logic signed [4:0]  mant_reg;
   logic signed [5:0]  power_reg;
   logic               ook_reg;
   logic               gauss_reg;
   logic [6:0]         if_ratio_reg;
   logic [4:0]         adc_ratio_reg;
   logic               bypass_reg;
   logic [5:0]         chbw_ratio_reg;

   always_comb begin
      word_first  = {freq_first_hi_i, freq_first_mid_i, freq_first_lo_i};    // [RULE2]
      word_second = {freq_second_hi_i, freq_second_mid_i, freq_second_lo_i}; // [RULE2]
      word_sel    = freq_select_i ? word_second : word_first;                // [RULE1]
      synth_word_next = word_sel[FREQ_W-1:1];                                // [RULE2]
      spur_spread_enable_next     = word_sel[SPUR_SPREAD_ENABLE_BIT];                                // [RULE2]
      if (band_choice_i) begin                                               // [RULE5]
         synth_base_next = HIGH_BAND_BASE;                                   // [RULE4]
         frac_shift_next = 4'(HIGH_BAND_SHIFT);
         power_next = 6'($signed({3'h0, tx_shift_exponent_i}) - HIGH_DEV_OFFSET); // [RULE8]
      end else begin
         synth_base_next = LOW_BAND_BASE;                                    // [RULE3]
         frac_shift_next = 4'(LOW_BAND_SHIFT);
         power_next = 6'($signed({3'h0, tx_shift_exponent_i}) - LOW_DEV_OFFSET); // [RULE8]
      end
      // Mantissa sign carries the symbol.
      if (tx_symbol_i) begin                                                 // [RULE9]
         mant_next = $signed({1'b0, tx_shift_mantissa_i});
      end else begin
         mant_next = -$signed({1'b0, tx_shift_mantissa_i});
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         synth_word_reg <= '0;
         spur_spread_enable_reg     <= 1'b0;
         band_reg       <= 1'b0;
         ref_div_reg    <= 3'h0;
         ref_ratio_reg  <= 4'h1;
         synth_base_reg <= LOW_BAND_BASE;
         frac_shift_reg <= 4'(LOW_BAND_SHIFT);
         mant_reg       <= '0;
         power_reg      <= '0;
         ook_reg        <= 1'b1;
         gauss_reg      <= 1'b0;
         if_ratio_reg   <= 7'(IF_DIV_BASE);
         adc_ratio_reg  <= 5'(ADC_PER_IF);
         bypass_reg     <= 1'b0;
         chbw_ratio_reg <= 6'h01;
      end else begin
         synth_word_reg <= synth_word_next;
         spur_spread_enable_reg     <= spur_spread_enable_next;
         band_reg       <= band_choice_i;
         ref_div_reg    <= ref_divider_i;
         ref_ratio_reg  <= {1'b0, ref_divider_i} + 4'h1;                       // [RULE6]
         synth_base_reg <= synth_base_next;
         frac_shift_reg <= frac_shift_next;
         mant_reg       <= mant_next;
         power_reg      <= power_next;
         ook_reg        <= (tx_shift_mantissa_i == 4'h0);                      // [RULE10]
         gauss_reg      <= tx_shaping_i;                                       // [RULE11]
         if_ratio_reg   <= 7'(IF_DIV_BASE) * ({4'h0, adc_divider_i} + 7'h01); // [RULE14]
         adc_ratio_reg  <= 5'(IF_DIV_BASE / ADC_PER_IF) * ({2'h0, adc_divider_i} + 5'h01); // [RULE14]
         bypass_reg     <= filter_bypass_i;
         chbw_ratio_reg <= {1'b0, decimation_factor_i} + 6'h01;                // [RULE16]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Adaptive data slicer.

   logic signed [11:0] min_reg;
   logic signed [11:0] min_next;
   logic signed [11:0] max_reg;
   logic signed [11:0] max_next;
   logic signed [11:0] level_reg;
   logic signed [11:0] level_next;
   logic signed [11:0] prev_reg;
   logic signed [11:0] prev_next;
   logic [2:0]         trans_reg;
   logic [2:0]         trans_next;
   fsksl_state_t       state_reg;
   fsksl_state_t       state_next;
   logic signed [12:0] exp_dev;
   logic signed [12:0] diff;
   logic signed [12:0] mean;
   logic signed [12:0] smooth;
   logic [3:0]         avg_shift;
   logic               transition;
   logic               locked_reg;

   always_comb begin
      exp_dev    = 13'($signed({1'b0, rx_shift_mantissa_i}) <<< rx_shift_exponent_i); // [RULE20]
      diff       = 13'(demod_freq_i) - 13'(prev_reg);
      transition = demod_valid_i && ((diff > exp_dev) || (-diff > exp_dev));   // [RULE20]
      mean       = (13'(min_reg) + 13'(max_reg)) >>> 1;                        // [RULE20]
      avg_shift  = {2'h0, slicer_avg_length_i};                                // [RULE21]
      smooth     = 13'(level_reg) + ((mean - 13'(level_reg)) >>> avg_shift);   // [RULE21]
      min_next   = min_reg;
      max_next   = max_reg;
      prev_next  = prev_reg;
      trans_next = trans_reg;
      level_next = level_reg;
      state_next = state_reg;
      if (demod_valid_i) begin
         if (demod_freq_i < min_reg) min_next = demod_freq_i;
         if (demod_freq_i > max_reg) max_next = demod_freq_i;
         if (transition) prev_next = demod_freq_i;
      end
      if (transition && trans_reg != MIN_TRANSITIONS) begin
         trans_next = trans_reg + 3'h1;
      end
      case (state_reg)
         FSKSL_HUNT: begin
            if (trans_reg == MIN_TRANSITIONS) state_next = FSKSL_LEVEL;      // [RULE21]
         end
         FSKSL_LEVEL: begin
            level_next = 12'(mean);
            state_next = FSKSL_LOCKED;
         end
         FSKSL_LOCKED: begin
            if (transition) level_next = 12'(smooth);                         // [RULE21]
         end
         default: state_next = FSKSL_HUNT;
      endcase
      if (slicer_avg_length_i == 2'h0) begin                                 // [RULE22]
         level_next = IF_CENTER;
         state_next = FSKSL_LOCKED;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         min_reg   <= 12'h7ff;
         max_reg   <= 12'h800;
         level_reg <= IF_CENTER;
         prev_reg  <= 12'h000;
         trans_reg <= 3'h0;
         state_reg <= FSKSL_HUNT;
         locked_reg <= 1'b0;
      end else begin
         min_reg   <= min_next;
         max_reg   <= max_next;
         level_reg <= level_next;
         prev_reg  <= prev_next;
         trans_reg <= trans_next;
         state_reg <= state_next;
         locked_reg <= (state_next == FSKSL_LOCKED);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bit synchronizer: majority vote over an oversampled bit period.

   logic [2:0] phase_reg;
   logic [2:0] phase_next;
   logic [3:0] ones_reg;
   logic [3:0] ones_next;
   logic       slice_prev_reg;
   logic       slice_prev_next;
   logic       slice_bit;
   logic       bit_push;
   logic       bit_val;
   logic       fifo_in_ready;
   logic       fifo_out_valid;
   logic [0:0] fifo_out_data;
   logic       out_data_reg;
   logic       out_valid_reg;
   logic       ovf_reg;
   logic       ovf_next;

   always_comb begin
      slice_bit       = demod_freq_i > level_reg;
      phase_next      = phase_reg;
      ones_next       = ones_reg;
      slice_prev_next = slice_prev_reg;
      bit_push        = 1'b0;
      bit_val         = 1'b0;
      if (demod_valid_i && state_reg == FSKSL_LOCKED) begin
         slice_prev_next = slice_bit;
         if (slice_bit != slice_prev_reg) begin                               // [RULE18]
            // Realign the bit clock so the next decision lands on the last of the symbol's OVERSAMPLE samples.
            phase_next = 3'h1;
            ones_next  = 4'(slice_bit);
         end else begin
            phase_next = phase_reg + 3'h1;
            ones_next  = ones_reg + 4'(slice_bit);
            if (phase_reg == 3'(OVERSAMPLE - 1)) begin                        // [RULE18]
               bit_push  = 1'b1;
               bit_val   = (ones_next >= 4'(VOTE_THRESH));
               ones_next = 4'h0;
            end
         end
      end
      ovf_next = ovf_reg | (bit_push & ~fifo_in_ready);
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         phase_reg      <= 3'h0;
         ones_reg       <= 4'h0;
         slice_prev_reg <= 1'b0;
         ovf_reg        <= 1'b0;
         out_data_reg   <= 1'b0;
         out_valid_reg  <= 1'b0;
      end else begin
         phase_reg      <= phase_next;
         ones_reg       <= ones_next;
         slice_prev_reg <= slice_prev_next;
         ovf_reg        <= ovf_next;
         out_data_reg   <= fifo_out_data[0];
         out_valid_reg  <= fifo_out_valid & bit_ready_i;
      end
   end

   fsksl_fifo #(
      .WIDTH (FIFO_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .mclk_i      (mclk_i),
      .rst_b_i     (rst_b_i),
      .in_data_i   (bit_val),
      .in_valid_i  (bit_push),
      .in_ready_o  (fifo_in_ready),
      .out_data_o  (fifo_out_data),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (bit_ready_i)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign synth_word_o         = synth_word_reg;
   assign spur_spread_enable_o = spur_spread_enable_reg;
   assign band_choice_o        = band_reg;
   assign ref_divider_o        = ref_div_reg;
   assign ref_div_ratio_o      = ref_ratio_reg;
   assign synth_base_o         = synth_base_reg;
   assign synth_frac_shift_o   = frac_shift_reg;
   assign tx_shift_mantissa_o  = mant_reg;
   assign tx_shift_power_o     = power_reg;
   assign ook_mode_o           = ook_reg;
   assign tx_gauss_o           = gauss_reg;
   assign if_div_ratio_o       = if_ratio_reg;
   assign adc_div_ratio_o      = adc_ratio_reg;
   assign filter_bypass_o      = bypass_reg;
   assign chbw_div_ratio_o     = chbw_ratio_reg;
   assign slice_level_o        = level_reg;
   assign slicer_locked_o      = locked_reg;
   assign bit_data_o           = out_data_reg;
   assign bit_valid_o          = out_valid_reg;
   assign fifo_overflow_o      = ovf_reg;

endmodule : fsksl_core
`default_nettype wire

/* File: rtl/fsksl_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module fsksl_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 8
) (
   input  wire logic             mclk_i,
   input  wire logic             rst_b_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_reg;
   logic [AW-1:0]    wr_next;
   logic [AW-1:0]    rd_reg;
   logic [AW-1:0]    rd_next;
   logic [AW:0]      cnt_reg;
   logic [AW:0]      cnt_next;
   logic             push;
   logic             pop;

   always_comb begin
      push     = in_valid_i && in_ready_o;
      pop      = out_ready_i && out_valid_o;
      wr_next  = push ? wr_reg + 1'b1 : wr_reg;
      rd_next  = pop ? rd_reg + 1'b1 : rd_reg;
      cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg  <= wr_next;
         rd_reg  <= rd_next;
         cnt_reg <= cnt_next;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (push) begin
         mem[wr_reg] <= in_data_i;
      end
   end

   assign in_ready_o  = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_reg != '0);
   assign out_data_o  = mem[rd_reg];
endmodule : fsksl_fifo
`default_nettype wire

/* File: rtl/fsksl_pkg.sv */
package fsksl_pkg;

   // Frequency word layout: high, middle and low bytes; bit 0 of the low byte is spur_spread_enable.
   localparam int FREQ_W         = 24;
   localparam int SPUR_SPREAD_ENABLE_BIT     = 0;
   // Synthesizer offsets scaled to 2^15 or 2^14 fractional units of the reference.
   localparam logic [17:0] LOW_BAND_BASE  = 18'h06000;
   localparam logic [17:0] HIGH_BAND_BASE = 18'h06000;
   localparam int LOW_BAND_SHIFT  = 15;
   localparam int HIGH_BAND_SHIFT = 14;
   // Deviation exponent offsets per band.
   localparam int LOW_DEV_OFFSET  = 16;
   localparam int HIGH_DEV_OFFSET = 15;
   // IF and decimation.
   localparam int IF_DIV_BASE     = 8;
   localparam int ADC_PER_IF      = 4;
   localparam int CHBW_BASE_HZ    = 307200;
   // Slicer.
   localparam logic [2:0] MIN_TRANSITIONS = 3'h3;
   localparam int SAMPLE_W        = 12;
   localparam logic [11:0] IF_CENTER = 12'h000;
   localparam int OVERSAMPLE      = 8;
   localparam logic [2:0] VOTE_THRESH = 3'h4;
   // FIFO.
   localparam int FIFO_W          = 1;
   localparam int FIFO_DEPTH      = 8;

   typedef enum logic [1:0] {
      FSKSL_HUNT   = 2'b00,
      FSKSL_LEVEL  = 2'b01,
      FSKSL_LOCKED = 2'b10
   } fsksl_state_t;

endpackage : fsksl_pkg

/* File: sim/fsksl_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module fsksl_assertions
   import fsksl_pkg::*;
(
   input wire logic               mclk_i,
   input wire logic               rst_b_i,
   input wire logic               tx_symbol_i,
   input wire logic [3:0]         tx_shift_mantissa_i,
   input wire logic [2:0]         tx_shift_exponent_i,
   input wire logic [4:0]         decimation_factor_i,
   input wire logic [1:0]         slicer_avg_length_i,
   input wire logic               band_choice_o,
   input wire logic [2:0]         ref_divider_o,
   input wire logic [3:0]         ref_div_ratio_o,
   input wire logic [3:0]         synth_frac_shift_o,
   input wire logic signed [4:0]  tx_shift_mantissa_o,
   input wire logic signed [5:0]  tx_shift_power_o,
   input wire logic               ook_mode_o,
   input wire logic [6:0]         if_div_ratio_o,
   input wire logic [4:0]         adc_div_ratio_o,
   input wire logic [5:0]         chbw_div_ratio_o,
   input wire logic signed [11:0] slice_level_o,
   input wire logic               slicer_locked_o,
   input wire logic               bit_valid_o,
   input wire logic               fifo_overflow_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_b_i);

   logic up_reg;
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         up_reg <= 1'b0;
      end else begin
         up_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   AST_BAND_SHIFT: assert property (up_reg |->
      synth_frac_shift_o == (band_choice_o ? 4'he : 4'hf))
      else $error("bad shift");
   AST_REF_RATIO: assert property (up_reg |->
      ref_div_ratio_o == {1'b0, ref_divider_o} + 4'h1)
      else $error("bad ref ratio");
   AST_DEV_POWER: assert property (up_reg |-> tx_shift_power_o ==
      $signed({3'b000, $past(tx_shift_exponent_i)}) - (band_choice_o ? 6'sh0f : 6'sh10))
      else $error("bad power");
   AST_SYMBOL_SIGN: assert property (up_reg |-> tx_shift_mantissa_o ==
      ($past(tx_symbol_i) ? $signed({1'b0, $past(tx_shift_mantissa_i)})
                          : -$signed({1'b0, $past(tx_shift_mantissa_i)})))
      else $error("bad sign");
   AST_OOK_MODE: assert property (up_reg |->
      ook_mode_o == ($past(tx_shift_mantissa_i) == 4'h0))
      else $error("bad ook");
   AST_IF_ADC: assert property (up_reg |->
      if_div_ratio_o == {adc_div_ratio_o, 2'b00})
      else $error("bad if ratio");
   AST_CHBW: assert property (up_reg |->
      chbw_div_ratio_o == {1'b0, $past(decimation_factor_i)} + 6'h01)
      else $error("bad chbw");
   AST_SETTLE_ZERO: assert property ((up_reg && slicer_avg_length_i == 2'h0) [*3] |->
      slice_level_o == 12'sh000 && slicer_locked_o)
      else $error("bad fixed level");
   AST_OVF_STICKY: assert property (fifo_overflow_o |=> fifo_overflow_o [*2])
      else $error("overflow cleared");

   COV_LOCK: cover property ($rose(slicer_locked_o));
   COV_OVF: cover property ($rose(fifo_overflow_o));
   COV_BIT: cover property (bit_valid_o);
endmodule : fsksl_assertions

bind fsksl_core fsksl_assertions i_fsksl_assertions (.mclk_i, .rst_b_i, .tx_symbol_i,
   .tx_shift_mantissa_i, .tx_shift_exponent_i, .decimation_factor_i, .slicer_avg_length_i,
   .band_choice_o, .ref_divider_o, .ref_div_ratio_o, .synth_frac_shift_o, .tx_shift_mantissa_o,
   .tx_shift_power_o, .ook_mode_o, .if_div_ratio_o, .adc_div_ratio_o, .chbw_div_ratio_o,
   .slice_level_o, .slicer_locked_o, .bit_valid_o, .fifo_overflow_o);
`default_nettype wire

/* File: sim/fsksl_tx_model.sv */
`timescale 1ns/1ns
`default_nettype none
module fsksl_tx_model
   import fsksl_pkg::*;
(
   input  wire logic               mclk_i,
   input  wire logic               start_i,
   input  wire logic [15:0]        bits_i,
   input  wire logic [4:0]         nbits_i,
   input  wire logic signed [11:0] center_i,
   input  wire logic signed [11:0] dev_i,
   output logic                    valid_o,
   output logic signed [11:0]      freq_o,
   output logic                    busy_o
);
   int n;
   initial begin
      valid_o = 1'b0;
      freq_o = 12'sh000;
      busy_o = 1'b0;
   end

   always begin
      @(posedge mclk_i);
      if (start_i) begin
         @(negedge mclk_i);
         busy_o = 1'b1;
         for (n = 0; n < int'(nbits_i) * OVERSAMPLE; n++) begin
            valid_o = 1'b1;
            freq_o = bits_i[int'(nbits_i) - 1 - n / OVERSAMPLE] ? center_i + dev_i
                                                                 : center_i - dev_i;
            @(negedge mclk_i);
         end
         valid_o = 1'b0;
         busy_o = 1'b0;
      end else begin
         @(negedge mclk_i);
         freq_o = ~freq_o;
      end
   end
endmodule : fsksl_tx_model
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
   import fsksl_pkg::*;
   logic mclk_i = 1'b0, rst_b_i = 1'b0, go = 1'b0, busy, demod_valid_i;
   logic [7:0] freq_first_hi_i = 8'h12, freq_first_mid_i = 8'h34, freq_first_lo_i = 8'h57;
   logic [7:0] freq_second_hi_i = 8'ha5, freq_second_mid_i = 8'h0f, freq_second_lo_i = 8'hc2;
   logic freq_select_i = 1'b0, band_choice_i = 1'b0, tx_shaping_i = 1'b0, tx_symbol_i = 1'b0;
   logic filter_bypass_i = 1'b0, bit_ready_i = 1'b0;
   logic [2:0] ref_divider_i = 3'h1, tx_shift_exponent_i = 3'h0, adc_divider_i = 3'h0;
   logic [3:0] tx_shift_mantissa_i = 4'h0, rx_shift_mantissa_i = 4'h4;
   logic [1:0] rx_shift_exponent_i = 2'h2, slicer_avg_length_i = 2'h2;
   logic [4:0] decimation_factor_i = 5'h00, nbits = 5'h00;
   logic [15:0] bits = 16'h0000;
   logic signed [11:0] center = 12'sh000, demod_freq_i, slice_level_o;
   logic [22:0] synth_word_o;
   logic [17:0] synth_base_o;
   logic spur_spread_enable_o, band_choice_o, ook_mode_o, tx_gauss_o, filter_bypass_o;
   logic slicer_locked_o, bit_data_o, bit_valid_o, fifo_overflow_o;
   logic [2:0] ref_divider_o;
   logic [3:0] ref_div_ratio_o, synth_frac_shift_o;
   logic signed [4:0] tx_shift_mantissa_o;
   logic signed [5:0] tx_shift_power_o;
   logic [6:0] if_div_ratio_o;
   logic [4:0] adc_div_ratio_o;
   logic [5:0] chbw_div_ratio_o;
   int err_count = 0;
   int checks_done = 0;
   int cyc = 0;

   fsksl_core i_fsksl_core (.mclk_i, .rst_b_i, .freq_first_hi_i, .freq_first_mid_i,
      .freq_first_lo_i, .freq_second_hi_i, .freq_second_mid_i, .freq_second_lo_i,
      .freq_select_i, .band_choice_i, .ref_divider_i, .tx_shift_mantissa_i, .tx_shift_exponent_i,
      .tx_shaping_i, .tx_symbol_i, .adc_divider_i, .filter_bypass_i, .decimation_factor_i,
      .rx_shift_exponent_i, .rx_shift_mantissa_i, .slicer_avg_length_i, .demod_valid_i,
      .demod_freq_i, .bit_ready_i, .synth_word_o, .spur_spread_enable_o, .band_choice_o,
      .ref_divider_o, .ref_div_ratio_o, .synth_base_o, .synth_frac_shift_o, .tx_shift_mantissa_o,
      .tx_shift_power_o, .ook_mode_o, .tx_gauss_o, .if_div_ratio_o, .adc_div_ratio_o,
      .filter_bypass_o, .chbw_div_ratio_o, .slice_level_o, .slicer_locked_o, .bit_data_o,
      .bit_valid_o, .fifo_overflow_o);

   fsksl_tx_model i_fsksl_tx_model (.mclk_i, .start_i(go), .bits_i(bits), .nbits_i(nbits),
      .center_i(center), .dev_i(12'sh100), .valid_o(demod_valid_i), .freq_o(demod_freq_i),
      .busy_o(busy));

   ////////////////////////////////////////////////////////////////////////////
   always #5 mclk_i = ~mclk_i;

   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         $display("mismatch at %0t: timeout", $time);
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (err_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic tick();
      @(negedge mclk_i);
   endtask : tick

   task automatic send(input logic [15:0] pat, input logic [4:0] n);
      int k;
      bits = pat;
      nbits = n;
      go = 1'b1;
      tick();
      go = 1'b0;
      k = 0;
      do begin
         @(posedge mclk_i);
         k++;
      end while (busy && k < 400);
      repeat (4) tick();
   endtask : send

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      int i, b, e, k;
      repeat (20) tick();
      rst_b_i = 1'b1;
      tick();
      chk(24'(slicer_locked_o), 24'h0, "early lock");
      tick();
      chk(24'(synth_word_o), 24'h091a2b, "word A");
      chk(24'(spur_spread_enable_o), 24'h1, "spur_spread_enable A");
      freq_select_i = 1'b1;
      tick();
      chk(24'(synth_word_o), 24'h5287e1, "word B");
      chk(24'(spur_spread_enable_o), 24'h0, "spur_spread_enable B");
      for (b = 0; b < 16; b++) begin
         band_choice_i = b[3];
         tx_shift_exponent_i = b[2:0];
         tick();
         chk(24'(synth_frac_shift_o), b[3] ? 24'he : 24'hf, "shift");
         chk(24'(synth_base_o), 24'h6000, "base");
         chk(24'(band_choice_o), 24'(b[3]), "band");
         e = (b % 8) - (b[3] ? 15 : 16);
         chk(24'(tx_shift_power_o[5:0]), 24'(e[5:0]), "power");
      end
      for (i = 1; i < 8; i++) begin
         ref_divider_i = 3'(i);
         tick();
         chk(24'(ref_div_ratio_o), 24'(i + 1), "ref ratio");
      end
      for (i = 0; i < 32; i++) begin
         tx_shift_mantissa_i = i[3:0];
         tx_symbol_i = i[4];
         tx_shaping_i = i[0];
         adc_divider_i = i[2:0];
         decimation_factor_i = 5'(i);
         filter_bypass_i = i[1];
         tick();
         e = i[4] ? i % 16 : -(i % 16);
         chk(24'(tx_shift_mantissa_o[4:0]), 24'(e[4:0]), "dev sign");
         chk(24'(ook_mode_o), 24'(i % 16 == 0), "ook");
         chk(24'(tx_gauss_o), 24'(i[0]), "shaping");
         chk(24'(if_div_ratio_o), 24'(8 * (i % 8 + 1)), "if ratio");
         chk(24'(adc_div_ratio_o), 24'(2 * (i % 8 + 1)), "adc ratio");
         chk(24'(filter_bypass_o), 24'(i[1]), "bypass");
         chk(24'(chbw_div_ratio_o), 24'(i + 1), "chbw ratio");
      end
      center = 12'sh040;
      send(16'h0155, 5'h0a);
      chk(24'(slicer_locked_o), 24'h1, "lock");
      chk(24'(slice_level_o), 24'h40, "level");
      slicer_avg_length_i = 2'h0;
      rst_b_i = 1'b0;
      repeat (2) tick();
      rst_b_i = 1'b1;
      center = 12'sh020;
      send(16'h02ce, 5'h0a);
      chk(24'(slice_level_o), 24'h0, "fixed level");
      chk(24'(fifo_overflow_o), 24'h1, "overflow");
      for (i = 0; i < 8; i++) begin
         bit_ready_i = 1'b1;
         tick();
         bit_ready_i = 1'b0;
         chk(24'(bit_valid_o), 24'h1, "valid");
         chk(24'(bit_data_o), 24'(bits[9 - i]), "bit");
         tick();
      end
      bit_ready_i = 1'b1;
      k = 0;
      repeat (4) begin
         tick();
         if (bit_valid_o !== 1'b0) k++;
      end
      chk(24'(k), 24'h0, "empty");
      print_verdict();
   end
endmodule : tb
`default_nettype wire
